// File: hdl/utf_pkg.sv
//------------------------------------------------------------------------------
// Purpose: Constants, states and carriers for the serial transmit framing block
// Assumes: core_clk at 125 MHz
// Notes:   Shared by the core and by the bench
//------------------------------------------------------------------------------
package utf_pkg;

	// -------------------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS    = 8;
	localparam int unsigned RX_MIN_PULSE_NS  = 1000;
	localparam int unsigned RX_MIN_PULSE_CYC =
		(RX_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  X16_LAST         = 4'hF;
	localparam logic [3:0]  X16_MID          = 4'h7;
	localparam logic [3:0]  IR_PULSE_TICKS   = 4'h3;

	// -------------------------------------------------------------------------
	// Depths and levels
	// -------------------------------------------------------------------------
	localparam logic [3:0]  TX_FIFO_DEPTH    = 4'h8;
	localparam logic [3:0]  TX_HALF_LEVEL    = 4'h4;
	localparam logic [3:0]  RX_FIFO_DEPTH    = 4'hC;
	localparam logic [3:0]  RTS_FREE_LIMIT   = 4'h4;
	localparam logic [1:0]  BUF_DEPTH        = 2'h2;
	localparam logic [2:0]  LAST_BIT_8       = 3'h7;
	localparam logic [2:0]  LAST_BIT_7       = 3'h6;
	localparam logic [15:0] DIV_ONE          = 16'h0001;

	// -------------------------------------------------------------------------
	// Transmit sequencer
	// -------------------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE   = 6'b00_0001,
		ST_START  = 6'b00_0010,
		ST_DATA   = 6'b00_0100,
		ST_PARITY = 6'b00_1000,
		ST_STOP   = 6'b01_0000,
		ST_STOP2  = 6'b10_0000
	} utf_state_type;

	// -------------------------------------------------------------------------
	// Carriers
	// -------------------------------------------------------------------------
	typedef struct packed {
		logic        module_enable;
		logic        transmitter_enable;
		logic        ignore_flow_control;
		logic        flow_change_irq_enable;
		logic        parity_enable;
		logic        parity_odd;
		logic        eight_bits;
		logic        two_stop;
		logic        irda_mode;
		logic        tx_pulse_polarity;
		logic        rx_pulse_polarity;
		logic        send_break_a;
		logic        force_parity_error;
		logic        rts_flow_mode;
		logic        rts_soft_level;
		logic        baud_src_external;
		logic        clock_pin_drive;
		logic        clock_mode_x1;
		logic [15:0] x16_divisor;
	} utf_cfg_type;

	typedef struct packed {
		logic busy;
		logic tx_space_available;
		logic tx_half;
		logic tx_empty;
		logic tx_empty_event;
		logic flow_pin_level_bit;
		logic flow_change_flag;
		logic flow_change_irq;
		logic tx_pin_level;
	} utf_status_type;

endpackage : utf_pkg

// File: hdl/utf_core.sv
//------------------------------------------------------------------------------
// Purpose: Character framing, 8-deep transmit FIFO, flow control, break and
//          infra-red pulse coding for a start-stop serial link
// Assumes: All inputs synchronous to core_clk; one clock domain
// Notes:   Bit clock is an enable derived from a x16 sample tick
// How it works
// - start, LSB-first data, stop; 7/8 bits
// - parity bit after MSB, before stop
// - IR zero is 3/16 bit pulse
// - IR zero bit gives one short pulse
// - pulse polarity bit inverts pulse and idle
// - NRZ mark high, space low
// - wait for clear-to-send before each character
// - ignore-flow bit bypasses clear-to-send
// - sample clear-to-send, flag toggles, raise interrupt
// - IR receive needs pulse of 1.0 us
// - request-to-send high when four slots free
// - request-to-send follows software bit otherwise
// - clock pin feeds divider or outputs bit clock
// - empty FIFO gives continuous idle level
// - next bit on falling bit clock edge
// - eight transmit and twelve receive characters
// - one empty interrupt per full drain
// - half condition below four characters
// - space flag; writes without space are dropped
// - break sends zeros while a character is sent, not when idle
// - disable flushes FIFO, finishes current character
// - parity sense even at 0, odd at 1
// - bit clock is x16 tick over 16, over 2 in x1 mode
//------------------------------------------------------------------------------
`timescale 1ns/100ps

module utf_core (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   resetn,
	// Configuration and control
	input  wire utf_pkg::utf_cfg_type   cfg,
	input  wire logic                   flow_change_clear,
	// Character write port
	input  wire logic                   wr_valid,
	input  wire logic [7:0]             wr_data,
	output logic                        wr_ready,
	// Status
	output utf_pkg::utf_status_type     status,
	// Serial pins
	output logic                        tx_pin,
	input  wire logic                   cts_n_pin,
	output logic                        rts_n_pin,
	input  wire logic                   rx_pin,
	output logic                        rx_line,
	input  wire logic [3:0]             rx_free_slots,
	// Clock pin, two-way
	input  wire logic                   serial_clock_pin_i,
	output logic                        serial_clock_pin_o,
	output logic                        serial_clock_pin_oe
);

	// -------------------------------------------------------------------------
	// Functions
	// -------------------------------------------------------------------------
	function automatic logic parity_of(input logic [7:0] d, input logic eight,
		input logic odd, input logic force_err);
		logic p;
		p = eight ? ^d : ^d[6:0];
		parity_of = p ^ odd ^ force_err;
	endfunction : parity_of

	// -------------------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------------------
	logic [15:0]              div_cnt_r;
	logic [15:0]              div_last;
	logic                     clk_pin_q_r;
	logic                     x16_tick;
	logic [3:0]               ph_r;
	logic                     x1_lvl_r;
	logic                     bit_fall;
	logic                     bit_rise;
	logic                     bit_clock_x1_level;
	logic [7:0]               fifo_mem [0:7];
	logic [2:0]               fifo_wp_r;
	logic [2:0]               fifo_rp_r;
	logic [3:0]               fifo_cnt_r;
	logic [7:0]               buf_mem [0:1];
	logic                     buf_wp_r;
	logic                     buf_rp_r;
	logic [1:0]               buf_cnt_r;
	logic [3:0]               total;
	logic                     push;
	logic                     move;
	logic                     take;
	logic                     flush;
	logic                     prev_nonempty_r;
	logic                     empty_event_r;
	utf_pkg::utf_state_type   state_r;
	utf_pkg::utf_state_type   state_nxt;
	logic [7:0]               shift_r;
	logic [2:0]               bit_idx_r;
	logic                     cur_bit_r;
	logic                     can_start;
	logic                     cts_level_r;
	logic                     cts_prev_r;
	logic                     change_flag_r;
	logic [3:0]               ir_cnt_r;
	logic                     tx_pin_r;
	logic                     rts_r;
	logic                     clk_out_r;
	logic [6:0]               rx_w_r;
	logic [3:0]               rx_hold_r;
	logic                     rx_zero_r;
	logic                     rx_act;
	logic                     rx_line_r;

	// -------------------------------------------------------------------------
	// Sample tick and bit clock
	// -------------------------------------------------------------------------
	assign div_last = (cfg.x16_divisor == 16'h0000) ? 16'h0000 :
		cfg.x16_divisor - utf_pkg::DIV_ONE;

	always_ff @(posedge core_clk) begin
		if (!resetn || !cfg.module_enable || div_cnt_r >= div_last) begin
			div_cnt_r <= 16'h0000;
		end else begin
			div_cnt_r <= div_cnt_r + utf_pkg::DIV_ONE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			clk_pin_q_r <= 1'b0;
		end else begin
			clk_pin_q_r <= serial_clock_pin_i;
		end
	end

	// External source counts rising edges of the clock pin
	assign x16_tick = cfg.module_enable & (cfg.baud_src_external ?
		(serial_clock_pin_i & ~clk_pin_q_r) : (div_cnt_r >= div_last));

	always_ff @(posedge core_clk) begin
		if (!resetn || !cfg.module_enable) begin
			ph_r     <= 4'h0;
			x1_lvl_r <= 1'b0;
		end else if (x16_tick) begin
			ph_r     <= ph_r + 4'h1;
			x1_lvl_r <= ~x1_lvl_r;
		end
	end

	assign bit_clock_x1_level = cfg.clock_mode_x1 ? x1_lvl_r : ph_r[3];
	assign bit_fall   = x16_tick & (cfg.clock_mode_x1 ? x1_lvl_r : (ph_r == utf_pkg::X16_LAST));
	assign bit_rise   = x16_tick & (cfg.clock_mode_x1 ? ~x1_lvl_r : (ph_r == utf_pkg::X16_MID));

	// -------------------------------------------------------------------------
	// Transmit FIFO and two-entry stage to the shifter
	// -------------------------------------------------------------------------
	assign total    = fifo_cnt_r + {2'b00, buf_cnt_r};
	assign flush    = ~cfg.transmitter_enable;
	assign wr_ready = cfg.transmitter_enable & (total < utf_pkg::TX_FIFO_DEPTH);
	assign push     = wr_valid & wr_ready;
	assign move     = (fifo_cnt_r != 4'h0) & (buf_cnt_r != utf_pkg::BUF_DEPTH);

	always_ff @(posedge core_clk) begin
		if (push) begin
			fifo_mem[fifo_wp_r] <= wr_data;
		end
		if (move) begin
			buf_mem[buf_wp_r] <= fifo_mem[fifo_rp_r];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn || flush) begin
			fifo_wp_r  <= 3'h0;
			fifo_rp_r  <= 3'h0;
			fifo_cnt_r <= 4'h0;
		end else begin
			if (push) begin
				fifo_wp_r <= fifo_wp_r + 3'h1;
			end
			if (move) begin
				fifo_rp_r <= fifo_rp_r + 3'h1;
			end
			fifo_cnt_r <= fifo_cnt_r + {3'h0, push} - {3'h0, move};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn || flush) begin
			buf_wp_r  <= 1'b0;
			buf_rp_r  <= 1'b0;
			buf_cnt_r <= 2'h0;
		end else begin
			if (move) begin
				buf_wp_r <= ~buf_wp_r;
			end
			if (take) begin
				buf_rp_r <= ~buf_rp_r;
			end
			buf_cnt_r <= buf_cnt_r + {1'b0, move} - {1'b0, take};
		end
	end

	// One event per drain: only the step from non-empty to empty posts it
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			prev_nonempty_r <= 1'b0;
			empty_event_r   <= 1'b0;
		end else begin
			prev_nonempty_r <= (total != 4'h0);
			empty_event_r   <= prev_nonempty_r & (total == 4'h0);
		end
	end

	// -------------------------------------------------------------------------
	// Flow control input
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cts_level_r <= 1'b1;
			cts_prev_r  <= 1'b1;
		end else if (bit_rise) begin
			cts_level_r <= cts_n_pin;
			cts_prev_r  <= cts_level_r;
		end
	end

	// A toggle seen in the clearing cycle keeps the flag set
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			change_flag_r <= 1'b0;
		end else if (cts_level_r != cts_prev_r) begin
			change_flag_r <= 1'b1;
		end else if (flow_change_clear) begin
			change_flag_r <= 1'b0;
		end
	end

	// -------------------------------------------------------------------------
	// Character sequencer
	// -------------------------------------------------------------------------
	assign can_start = (buf_cnt_r != 2'h0) & cfg.transmitter_enable & cfg.module_enable &
		(cfg.ignore_flow_control | ~cts_level_r);
	assign take = bit_fall & can_start & ((state_r == utf_pkg::ST_IDLE) |
		(state_r == utf_pkg::ST_STOP & ~cfg.two_stop) | (state_r == utf_pkg::ST_STOP2));

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			utf_pkg::ST_IDLE: begin
				if (take) begin
					state_nxt = utf_pkg::ST_START;
				end
			end
			utf_pkg::ST_START: begin
				state_nxt = utf_pkg::ST_DATA;
			end
			utf_pkg::ST_DATA: begin
				if (bit_idx_r == (cfg.eight_bits ? utf_pkg::LAST_BIT_8 :
					utf_pkg::LAST_BIT_7)) begin
					state_nxt = cfg.parity_enable ? utf_pkg::ST_PARITY : utf_pkg::ST_STOP;
				end
			end
			utf_pkg::ST_PARITY: begin
				state_nxt = utf_pkg::ST_STOP;
			end
			utf_pkg::ST_STOP: begin
				if (cfg.two_stop) begin
					state_nxt = utf_pkg::ST_STOP2;
				end else begin
					state_nxt = take ? utf_pkg::ST_START : utf_pkg::ST_IDLE;
				end
			end
			utf_pkg::ST_STOP2: begin
				state_nxt = take ? utf_pkg::ST_START : utf_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_r <= utf_pkg::ST_IDLE;
		end else if (bit_fall) begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			shift_r   <= 8'h00;
			bit_idx_r <= 3'h0;
			cur_bit_r <= 1'b1;
		end else if (bit_fall) begin
			unique case (state_nxt)
				utf_pkg::ST_START: begin
					shift_r   <= buf_mem[buf_rp_r];
					bit_idx_r <= 3'h0;
					cur_bit_r <= 1'b0;
				end
				utf_pkg::ST_DATA: begin
					if (state_r == utf_pkg::ST_DATA) begin
						bit_idx_r <= bit_idx_r + 3'h1;
						cur_bit_r <= shift_r[1];
						shift_r   <= {1'b0, shift_r[7:1]};
					end else begin
						cur_bit_r <= shift_r[0];
					end
				end
				default: begin
					cur_bit_r <= 1'b1;
				end
			endcase
		end
	end

	logic [7:0] sent_r;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sent_r <= 8'h00;
		end else if (take) begin
			sent_r <= buf_mem[buf_rp_r];
		end
	end

	// -------------------------------------------------------------------------
	// Transmit pin
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn || bit_fall) begin
			ir_cnt_r <= 4'h0;
		end else if (x16_tick && ir_cnt_r != utf_pkg::X16_LAST) begin
			ir_cnt_r <= ir_cnt_r + 4'h1;
		end
	end

	logic line_bit;
	logic par_bit;
	assign par_bit  = parity_of(sent_r, cfg.eight_bits, cfg.parity_odd, cfg.force_parity_error);
	assign line_bit = (state_r == utf_pkg::ST_IDLE) ? 1'b1 :
		cfg.send_break_a ? 1'b0 :
		(state_r == utf_pkg::ST_PARITY) ? par_bit : cur_bit_r;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tx_pin_r <= 1'b1;
		end else if (!cfg.irda_mode) begin
			tx_pin_r <= line_bit;
		end else if (!line_bit && ir_cnt_r < utf_pkg::IR_PULSE_TICKS) begin
			tx_pin_r <= ~cfg.tx_pulse_polarity;
		end else begin
			tx_pin_r <= cfg.tx_pulse_polarity;
		end
	end

	assign tx_pin = tx_pin_r;

	// -------------------------------------------------------------------------
	// Request-to-send and clock pin
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rts_r     <= 1'b1;
			clk_out_r <= 1'b0;
		end else begin
			if (cfg.rts_flow_mode) begin
				rts_r <= (rx_free_slots <= utf_pkg::RTS_FREE_LIMIT) |
					(rx_free_slots > utf_pkg::RX_FIFO_DEPTH);
			end else begin
				rts_r <= cfg.rts_soft_level;
			end
			clk_out_r <= bit_clock_x1_level;
		end
	end

	assign rts_n_pin           = rts_r;
	assign serial_clock_pin_o  = clk_out_r;
	assign serial_clock_pin_oe = cfg.clock_pin_drive & ~cfg.baud_src_external;

	// -------------------------------------------------------------------------
	// Infra-red receive pulse qualifier
	// -------------------------------------------------------------------------
	assign rx_act = rx_pin ^ cfg.rx_pulse_polarity;

	always_ff @(posedge core_clk) begin
		if (!resetn || !rx_act) begin
			rx_w_r <= 7'h00;
		end else if (rx_w_r != 7'(utf_pkg::RX_MIN_PULSE_CYC)) begin
			rx_w_r <= rx_w_r + 7'h01;
		end
	end

	// A qualified pulse reads as a zero for one bit time
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rx_zero_r <= 1'b0;
			rx_hold_r <= 4'h0;
		end else if (rx_act && rx_w_r == 7'(utf_pkg::RX_MIN_PULSE_CYC - 1)) begin
			rx_zero_r <= 1'b1;
			rx_hold_r <= 4'h0;
		end else if (rx_zero_r && x16_tick) begin
			rx_hold_r <= rx_hold_r + 4'h1;
			if (rx_hold_r == utf_pkg::X16_LAST) begin
				rx_zero_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rx_line_r <= 1'b1;
		end else begin
			rx_line_r <= cfg.irda_mode ? ~rx_zero_r : rx_pin;
		end
	end

	assign rx_line = rx_line_r;

	// -------------------------------------------------------------------------
	// Status
	// -------------------------------------------------------------------------
	assign status.busy               = (state_r != utf_pkg::ST_IDLE);
	assign status.tx_space_available = (total < utf_pkg::TX_FIFO_DEPTH);
	assign status.tx_half            = (total < utf_pkg::TX_HALF_LEVEL);
	assign status.tx_empty           = (total == 4'h0);
	assign status.tx_empty_event     = empty_event_r;
	assign status.flow_pin_level_bit = cts_level_r;
	assign status.flow_change_flag   = change_flag_r;
	assign status.flow_change_irq    = change_flag_r & cfg.flow_change_irq_enable;
	assign status.tx_pin_level       = tx_pin_r;

endmodule : utf_core

// File: hdl/utf_unused_guard.sv
`timescale 1ns/100ps

// File: tb/utf_core_chk.sv
// Purpose: Port assertions for the serial framing core
// Assumes: x16_divisor of 1, so one x16 tick per core_clk
// Notes:   Bound to utf_core below
`timescale 1ns/100ps

module utf_core_chk (
	// Clock and reset
	input wire logic                    core_clk,
	input wire logic                    resetn,
	// Observed ports
	input wire utf_pkg::utf_cfg_type    cfg,
	input wire logic                    wr_ready,
	input wire utf_pkg::utf_status_type status,
	input wire logic                    tx_pin,
	input wire logic                    rts_n_pin,
	input wire logic [3:0]              rx_free_slots
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_refuse_when_off: assert property (
		!cfg.transmitter_enable |-> !wr_ready) else $error("ready while disabled");
	a_space_flag_ready: assert property (
		cfg.transmitter_enable |-> status.tx_space_available == wr_ready)
		else $error("space flag and ready disagree");
	a_nrz_idle_high: assert property (
		(!status.busy && !cfg.irda_mode)[*2] |-> tx_pin) else $error("nrz idle not high");
	a_ir_idle_level: assert property (
		(!status.busy && cfg.irda_mode)[*2] |-> tx_pin == $past(cfg.tx_pulse_polarity))
		else $error("ir idle level wrong");
	a_start_bit_low: assert property (
		$rose(status.busy) && !cfg.irda_mode |-> ##[0:1] !tx_pin) else $error("no start bit");
	a_start_needs_cts: assert property (
		$rose(status.busy) && !cfg.ignore_flow_control |-> !$past(status.flow_pin_level_bit))
		else $error("start while clear-to-send negated");
	a_toggle_sets_flag: assert property (
		$changed(status.flow_pin_level_bit) |-> ##[0:1] status.flow_change_flag)
		else $error("toggle did not set flag");
	a_flag_raises_irq: assert property (
		$rose(status.flow_change_flag) && cfg.flow_change_irq_enable
		|-> ##[0:1] status.flow_change_irq) else $error("no change interrupt");
	a_rts_negated_full: assert property (
		(cfg.rts_flow_mode && rx_free_slots <= 4'h4)[*2] |-> rts_n_pin)
		else $error("request-to-send not negated");
	a_rts_asserted_room: assert property (
		(cfg.rts_flow_mode && rx_free_slots > 4'h4)[*2] |-> !rts_n_pin)
		else $error("request-to-send not asserted");
	a_empty_event_pulse: assert property (
		$rose(status.tx_empty) |-> ##[0:1] status.tx_empty_event) else $error("no empty event");
	a_ir_pulse_width: assert property (
		cfg.irda_mode && $past(cfg.irda_mode) && $stable(cfg.tx_pulse_polarity)
		&& tx_pin != cfg.tx_pulse_polarity && $past(tx_pin) == cfg.tx_pulse_polarity
		|-> (tx_pin != cfg.tx_pulse_polarity)[*3] ##1 tx_pin == cfg.tx_pulse_polarity)
		else $error("ir pulse not three ticks");

	c_char_start: cover property ($rose(status.busy));
	c_ir_pulse: cover property (cfg.irda_mode && $rose(tx_pin));
	c_flow_flag: cover property ($rose(status.flow_change_flag));
endmodule : utf_core_chk

bind utf_core utf_core_chk i_utf_core_chk (.core_clk(core_clk), .resetn(resetn), .cfg(cfg),
	.wr_ready(wr_ready), .status(status), .tx_pin(tx_pin), .rts_n_pin(rts_n_pin),
	.rx_free_slots(rx_free_slots));

// File: tb/utf_far_model.sv
// Purpose: Far-end receiver and clear-to-send source for the serial core
// Assumes: One bit lasts BIT_CYC core_clk cycles
// Notes:   Bit 0 of frame is the start bit; unused upper bits read 0
`timescale 1ns/100ps

module utf_far_model #(
	parameter int BIT_CYC = 16
) (
	// Clock
	input  wire logic       core_clk,
	// Line from the core
	input  wire logic       tx_pin,
	input  wire logic       listen,
	input  wire logic [3:0] nbits,
	// Flow control towards the core
	input  wire logic       cts_hold,
	output logic            cts_n_pin,
	// Captured character
	output logic [11:0]     frame,
	output int              frames
);
	assign cts_n_pin = cts_hold;

	initial begin
		frames = 0;
		frame  = 12'h000;
	end

	// Sample mid-bit; stop at the last bit so a back-to-back start is not missed
	always begin
		@(negedge tx_pin iff listen);
		frame = 12'h000;
		repeat (BIT_CYC / 2) @(posedge core_clk);
		for (int i = 0; i < nbits; i++) begin
			frame[i] = tx_pin;
			if (i < nbits - 1)
				repeat (BIT_CYC) @(posedge core_clk);
		end
		frames++;
	end
endmodule : utf_far_model

// File: tb/tb.sv
// Purpose: Self-checking bench for the serial framing core
// Assumes: x16_divisor of 1, so one bit lasts 16 core_clk cycles
// Notes:   Far end is utf_far_model; clear-to-send stalls fill the FIFO
`timescale 1ns/100ps

module tb;
	logic                    core_clk = 1'b0;
	logic                    resetn = 1'b0;
	utf_pkg::utf_cfg_type    cfg;
	logic                    flow_change_clear = 1'b0;
	logic                    wr_valid = 1'b0;
	logic [7:0]              wr_data = 8'h00;
	logic                    rx_pin = 1'b1, ck_i = 1'b0;
	logic [3:0]              rx_free_slots = 4'hC;
	logic                    cts_hold = 1'b1;
	logic [3:0]              nbits = 4'hA;
	logic                    wr_ready, tx_pin, rts_n_pin, rx_line, ck_o, ck_oe, cts_n_pin, ok, prev;
	utf_pkg::utf_status_type status;
	logic [11:0]             frame;
	int                      frames, n, f0, err_total = 0, checks = 0, cyc = 0;

	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) ck_i <= ~ck_i;

	utf_core i_utf_core (.core_clk(core_clk), .resetn(resetn), .cfg(cfg),
		.flow_change_clear(flow_change_clear), .wr_valid(wr_valid), .wr_data(wr_data),
		.wr_ready(wr_ready), .status(status), .tx_pin(tx_pin), .cts_n_pin(cts_n_pin),
		.rts_n_pin(rts_n_pin), .rx_pin(rx_pin), .rx_line(rx_line), .rx_free_slots(rx_free_slots),
		.serial_clock_pin_i(ck_i), .serial_clock_pin_o(ck_o), .serial_clock_pin_oe(ck_oe));
	utf_far_model i_utf_far_model (.core_clk(core_clk), .tx_pin(tx_pin),
		.listen(resetn & ~cfg.irda_mode), .nbits(nbits), .cts_hold(cts_hold),
		.cts_n_pin(cts_n_pin), .frame(frame), .frames(frames));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
	endtask : tick

	task automatic put(input logic [7:0] d, output logic acc);
		int w;
		w = 0;
		@(posedge core_clk);
		wr_valid <= 1'b1;
		wr_data  <= d;
		@(posedge core_clk);
		while (wr_ready !== 1'b1 && w < 60) begin
			w++;
			@(posedge core_clk);
		end
		acc = (wr_ready === 1'b1);
		wr_valid <= 1'b0;
	endtask : put

	task automatic wait_fr(input int k);
		for (int i = 0; i < 3000 && frames < k; i++)
			@(posedge core_clk);
		chk("frames", 12'(k), 12'(frames));
	endtask : wait_fr

	task automatic wait_busy(input logic v);
		for (int i = 0; i < 400 && status.busy !== v; i++)
			@(posedge core_clk);
	endtask : wait_busy

	function automatic logic [11:0] expf(input logic [7:0] d);
		logic [11:0] f;
		int b;
		f = 12'h000;
		b = cfg.eight_bits ? 8 : 7;
		for (int i = 0; i < b; i++)
			f[i + 1] = d[i];
		if (cfg.parity_enable) begin
			f[b + 1] = ^(d & (cfg.eight_bits ? 8'hFF : 8'h7F)) ^ cfg.parity_odd;
			f[b + 1] = f[b + 1] ^ cfg.force_parity_error;
			b++;
		end
		f[b + 1] = 1'b1;
		f[b + 2] = cfg.two_stop;
		return f;
	endfunction : expf

	task automatic xfer(input logic [7:0] d, input logic brk);
		f0 = frames;
		nbits = 4'(2 + (cfg.eight_bits ? 8 : 7) + cfg.parity_enable + cfg.two_stop);
		put(d, ok);
		wait_fr(f0 + 1);
		chk("frame", brk ? 12'h000 : expf(d), frame);
	endtask : xfer

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			end_sim();
		end
	end

	initial begin
		cfg = '0;
		cfg.module_enable = 1'b1;
		cfg.transmitter_enable = 1'b1;
		cfg.ignore_flow_control = 1'b1;
		cfg.eight_bits = 1'b1;
		cfg.x16_divisor = 16'h0001;
		tick(6);
		resetn <= 1'b1;
		tick(40);
		xfer(8'h41, 1'b0);
		xfer(8'hA5, 1'b0);
		for (int i = 0; i < 4; i++) begin
			tick(1);
			cfg.parity_enable <= 1'b1;
			cfg.parity_odd <= i[0];
			cfg.eight_bits <= i[1];
			cfg.two_stop <= i[0];
			cfg.force_parity_error <= i[0] & i[1];
			tick(1);
			xfer(8'hC3, 1'b0);
		end
		$display("test framing done");
		tick(1);
		cfg.parity_enable <= 1'b0;
		cfg.eight_bits <= 1'b1;
		cfg.two_stop <= 1'b0;
		cfg.ignore_flow_control <= 1'b0;
		nbits = 4'hA;
		tick(40);
		n = 0;
		for (int i = 0; i < 9; i++) begin
			put(8'h3C, ok);
			n += ok;
		end
		chk("accepted", 12'h008, 12'(n));
		chk("busy held", 12'h000, 12'(status.busy));
		chk("half", 12'h000, 12'(status.tx_half));
		f0 = frames;
		cts_hold <= 1'b0;
		wait_busy(1'b1);
		cts_hold <= 1'b1;
		wait_fr(f0 + 1);
		chk("frame", expf(8'h3C), frame);
		tick(64);
		chk("held off", 12'(f0 + 1), 12'(frames));
		cts_hold <= 1'b0;
		wait_fr(f0 + 8);
		tick(20);
		chk("empty", 12'h001, 12'(status.tx_empty));
		chk("half", 12'h001, 12'(status.tx_half));
		chk("space", 12'h001, 12'(status.tx_space_available));
		$display("test fifo done");
		cfg.ignore_flow_control <= 1'b1;
		f0 = frames;
		for (int i = 0; i < 3; i++)
			put(8'h5A, ok);
		wait_busy(1'b1);
		tick(30);
		chk("busy", 12'h001, 12'(status.busy));
		cfg.transmitter_enable <= 1'b0;
		tick(2);
		chk("flushed", 12'h001, 12'(status.tx_empty));
		chk("ready off", 12'h000, 12'(wr_ready));
		wait_fr(f0 + 1);
		tick(300);
		chk("no more", 12'(f0 + 1), 12'(frames));
		cfg.transmitter_enable <= 1'b1;
		cfg.send_break_a <= 1'b1;
		tick(2);
		xfer(8'hFF, 1'b1);
		wait_busy(1'b0);
		cfg.send_break_a <= 1'b0;
		$display("test disable and break done");
		rx_pin <= 1'b0;
		for (int p = 0; p < 2; p++) begin
			tick(20);
			cfg.irda_mode <= 1'b1;
			cfg.tx_pulse_polarity <= p[0];
			tick(5);
			chk("ir idle", 12'(p[0]), 12'(tx_pin));
			put(8'hF0, ok);
			n = 0;
			prev = tx_pin;
			for (int i = 0; i < 200; i++) begin
				@(posedge core_clk);
				n += (tx_pin !== p[0] && prev === p[0]);
				prev = tx_pin;
			end
			chk("ir pulses", 12'h005, 12'(n));
		end
		tick(40);
		rx_pin <= 1'b1;
		tick(100);
		rx_pin <= 1'b0;
		tick(10);
		chk("rx short", 12'h001, 12'(rx_line));
		rx_pin <= 1'b1;
		tick(135);
		chk("rx long", 12'h000, 12'(rx_line));
		rx_pin <= 1'b0;
		tick(40);
		chk("rx idle", 12'h001, 12'(rx_line));
		cfg.irda_mode <= 1'b0;
		rx_pin <= 1'b1;
		$display("test irda done");
		cfg.flow_change_irq_enable <= 1'b1;
		flow_change_clear <= 1'b1;
		tick(1);
		flow_change_clear <= 1'b0;
		tick(2);
		chk("flag clear", 12'h000, 12'(status.flow_change_flag));
		cts_hold <= 1'b1;
		tick(40);
		chk("cts level", 12'h001, 12'(status.flow_pin_level_bit));
		chk("cts flag", 12'h001, 12'(status.flow_change_flag));
		cfg.rts_flow_mode <= 1'b1;
		rx_free_slots <= 4'h4;
		tick(3);
		chk("rts full", 12'h001, 12'(rts_n_pin));
		rx_free_slots <= 4'h5;
		tick(3);
		chk("rts room", 12'h000, 12'(rts_n_pin));
		cfg.rts_flow_mode <= 1'b0;
		cfg.rts_soft_level <= 1'b1;
		cfg.clock_pin_drive <= 1'b1;
		tick(3);
		chk("rts soft", 12'h001, 12'(rts_n_pin));
		chk("clock oe", 12'h001, 12'(ck_oe));
		for (int e = 0; e < 2; e++) begin
			cfg.baud_src_external <= e[0];
			tick(8);
			n = 0;
			for (int i = 0; i < 128; i++) begin
				prev = ck_o;
				@(posedge core_clk);
				n += (ck_o === 1'b1 && prev === 1'b0);
			end
			chk("bit clock", e[0] ? 12'h004 : 12'h008, 12'(n));
		end
		$display("test flow done");
		wait_busy(1'b0);
		cfg.module_enable <= 1'b0;
		tick(5);
		end_sim();
	end
endmodule : tb
